// ===== src/cswref_clock_switch.sv
// cswref_clock_switch: APB oscillator control and reference clock output.
// assumes oscillator status and base clock levels are synchronous to clock;
// the oscillators themselves, the fail-safe detector and the core are outside.
//
// Summary of operation
// RQ1: switching needs switch-enable configuration bit zero
// RQ2: disabled: new source ignored, current shows reset
// RQ3: disabled: request bit ignores writes, reads zero
// RQ4: high byte opens after 78h then 9Ah
// RQ5: low byte opens after 46h then 57h
// RQ6: equal sources clear request, abort switch
// RQ7: accepted switch clears lock and fail flags
// RQ8: start target, wait startup timer or lock
// RQ9: count ten new-clock cycles before switching
// RQ10: done: clear request, copy new to current
// RQ11: stop old source, keep needed exceptions
// RQ12: switching never stalls bus or core
// RQ13: software avoids direct PLL-to-PLL switches
// RQ14: primary submode fixed by configuration only
// RQ15: software masks interrupts during unlock writes
// RQ16: software polls request bit, then lock bit
// RQ17: output enable drives divided clock on pin
// RQ18: source select picks primary or system clock
// RQ19: sleep run needs sleep-run and source bits
// RQ20: divisor divides base clock by power two
// RQ21: three-bit source codes as enumerated
// RQ22: fail-safe plus lock bit blocks switching
// RQ23: stray write closes any open unlock
//
// Our own choices: the APB interface to the registers and the address map.
module cswref_clock_switch (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration and system state
    input wire cswref_pkg::cswref_cfg_t cfgWord,
    input wire logic wdtEnabled,
    input wire logic sleepMode,
    // oscillators
    input wire cswref_pkg::cswref_osc_stat_t oscStat,
    output cswref_pkg::cswref_osc_t oscEnable,
    output cswref_pkg::cswref_src_t sysClkSource,
    output logic [1:0] primarySubmode,
    // reference clock
    input wire logic primaryClk,
    input wire logic systemClk,
    output logic refclkPin,
    output logic refclkOe
);
    import cswref_pkg::*;

    // =========================================================================
    // helpers
    function automatic cswref_osc_t srcNeeds(input cswref_src_t src);
        cswref_osc_t need;
        need = '0;
        unique case (src)
            SRC_FRC, SRC_FRC_DIV: need.fast_rc_oscillator = 1'b1;
            SRC_FRC_PLL: begin
                need.fast_rc_oscillator = 1'b1;
                need.pll = 1'b1;
            end
            SRC_PRI: need.pri = 1'b1;
            SRC_PRI_PLL: begin
                need.pri = 1'b1;
                need.pll = 1'b1;
            end
            SRC_SEC: need.sec = 1'b1;
            SRC_LOW_POWER_RC_OSCILLATOR: need.low_power_rc_oscillator = 1'b1;
            SRC_RSVD: need = '0;
        endcase
        return need;
    endfunction

    function automatic logic usesPll(input cswref_src_t src);
        return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    // one step of a two-key unlock, advanced by every completed write
    function automatic cswref_key_t keyStep(input cswref_key_t cur, input logic hit,
                                            input logic [7:0] data,
                                            input logic [7:0] first,
                                            input logic [7:0] second);
        cswref_key_t nxt;
        nxt = KEY_IDLE;
        if (hit && cur != KEY_OPEN) begin
            if (cur == KEY_FIRST && data == second) begin
                nxt = KEY_OPEN;
            end else if (data == first) begin
                nxt = KEY_FIRST;
            end
        end
        return nxt;
    endfunction

    // =========================================================================
    // reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // =========================================================================
    // state
    cswref_cfg_t cfgReg;
    logic cfgLoadedReg;
    cswref_key_t hiKeyReg;
    cswref_key_t loKeyReg;
    cswref_src_t noscReg;
    cswref_src_t coscReg;
    cswref_src_t targetReg;
    cswref_state_t stateReg;
    cswref_state_t stateNext;
    logic [3:0] settleCnt;
    logic oswenReg;
    logic clklockReg;
    logic lockReg;
    logic cfReg;
    logic poscenReg;
    logic soscenReg;
    logic [15:0] refCtrlReg;

    // =========================================================================
    // bus decode
    wire oscHit = paddr == OSC_CTRL_OFS;
    wire refHit = paddr == REF_CTRL_OFS;
    wire accDone = psel & penable & pready;
    wire wrAcc = accDone & pwrite;
    wire hiWr = wrAcc & oscHit & pstrb[1];
    wire loWr = wrAcc & oscHit & pstrb[0];
    wire [7:0] hiByte = pwdata[15:8];
    wire [7:0] loByte = pwdata[7:0];
    wire hiCommit = hiWr & (hiKeyReg == KEY_OPEN);
    wire loCommit = loWr & (loKeyReg == KEY_OPEN);
    // RQ1 enable gating
    wire switchEnabled = cfgLoadedReg & ~cfgReg.switchDisable;
    wire fscmEnabled = switchEnabled & ~cfgReg.fscmDisable;
    // RQ22 selection lock
    wire selLocked = fscmEnabled & clklockReg;
    wire swAllowed = switchEnabled & ~selLocked;
    wire busy = stateReg != ST_IDLE;
    wire redundant = noscReg == coscReg;
    wire accept = (stateReg == ST_IDLE) & oswenReg & switchEnabled & ~redundant;
    wire primaryCrystal = cfgReg.primarySubmode != SUBMODE_EC;

    // RQ8 readiness of the target
    wire targetReady = usesPll(targetReg) ? oscStat.pllLocked
                     : (targetReg == SRC_PRI && primaryCrystal) ? oscStat.ostExpired : 1'b1;

    // =========================================================================
    // configuration capture, once after reset release
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            cfgReg <= CFG_RESET;
            cfgLoadedReg <= 1'b0;
        end else if (!cfgLoadedReg) begin
            // RQ14 submode from configuration
            cfgReg <= cfgWord;
            cfgLoadedReg <= 1'b1;
        end
    end

    // =========================================================================
    // unlock tracking
    // RQ23 stray write closes
    wire cswref_key_t hiKeyNext = keyStep(hiKeyReg, hiWr, hiByte, KEY_HI_FIRST, KEY_HI_SECOND);
    wire cswref_key_t loKeyNext = keyStep(loKeyReg, loWr, loByte, KEY_LO_FIRST, KEY_LO_SECOND);

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            hiKeyReg <= KEY_IDLE;
            loKeyReg <= KEY_IDLE;
        end else if (wrAcc) begin
            // RQ4 high key
            hiKeyReg <= hiKeyNext;
            // RQ5 low key
            loKeyReg <= loKeyNext;
        end
    end

    // =========================================================================
    // switch sequencer
    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            ST_IDLE: if (accept) stateNext = ST_START;
            ST_START: stateNext = ST_WAIT;
            ST_WAIT: if (targetReady) stateNext = ST_SETTLE;
            ST_SETTLE: begin
                if (oscStat.newClkTick && settleCnt == SETTLE_COUNT - 4'h1) begin
                    stateNext = ST_SWITCH;
                end
            end
            ST_SWITCH: stateNext = ST_IDLE;
            default: stateNext = ST_IDLE;
        endcase
    end

    // RQ9 new-clock count
    wire [3:0] settleNext = (stateReg != ST_SETTLE) ? 4'h0
                          : oscStat.newClkTick ? settleCnt + 4'h1 : settleCnt;
    // RQ6 redundant abort
    wire hwClrOswen = ((stateReg == ST_IDLE) & oswenReg & redundant) | (stateReg == ST_SWITCH);
    // RQ3 request writes gated
    wire swSetOswen = loCommit & loByte[SWITCH_REQUEST_BIT_BIT] & swAllowed & ~busy;
    wire oswenNext = switchEnabled & (swSetOswen | (oswenReg & ~hwClrOswen));
    // RQ2 current follows configuration
    wire cswref_src_t coscNext = !switchEnabled ? cswref_src_t'(cfgLoadedReg ? cfgReg.resetSource
        : cfgWord.resetSource) : (stateReg == ST_SWITCH) ? targetReg : coscReg;
    // RQ7 clear on accept, fail event wins over any clear
    wire cfNext = oscStat.clockFail | (cfReg & ~accept & ~(loCommit & ~loByte[CF_BIT]));
    wire lockNext = ~accept & oscStat.pllLocked & usesPll(busy ? targetReg : coscReg);

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            stateReg <= ST_IDLE;
            settleCnt <= 4'h0;
            targetReg <= SRC_FRC;
            coscReg <= SRC_FRC;
            oswenReg <= 1'b0;
            cfReg <= 1'b0;
            lockReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            settleCnt <= settleNext;
            if (accept) targetReg <= noscReg;
            // RQ10 completion update
            coscReg <= coscNext;
            oswenReg <= oswenNext;
            cfReg <= cfNext;
            lockReg <= lockNext;
        end
    end

    // =========================================================================
    // software fields
    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            noscReg <= SRC_FRC;
            clklockReg <= 1'b0;
            poscenReg <= 1'b0;
            soscenReg <= 1'b0;
            refCtrlReg <= REF_CTRL_RESET;
        end else begin
            // RQ2 new source follows reset source until enabled
            if (!cfgLoadedReg) begin
                noscReg <= cswref_src_t'(cfgWord.resetSource);
            end else if (hiCommit && swAllowed) begin
                // RQ21 three-bit code
                noscReg <= cswref_src_t'(pwdata[NOSC_LSB +: 3]);
            end
            if (loCommit) begin
                clklockReg <= clklockReg | loByte[CLOCK_SELECT_LOCK_BIT];
                poscenReg <= loByte[PRIMARY_KEEP_IN_SLEEP_BIT];
                soscenReg <= loByte[SECONDARY_OSC_ENABLE_BIT];
            end
            if (wrAcc && refHit && pstrb[1]) begin
                refCtrlReg <= {hiByte, 8'h00} & REF_CTRL_MASK;
            end
        end
    end

    // =========================================================================
    // oscillator enables
    wire roEnable = refCtrlReg[REFCLK_OUTPUT_ENABLE_BIT];
    wire roSleepRun = refCtrlReg[RO_SLEEP_BIT];
    wire roSelPrimary = refCtrlReg[RO_SEL_BIT];
    wire [3:0] roDivisor = refCtrlReg[RO_DIV_LSB +: 4];
    wire cswref_osc_t runNeeds = srcNeeds(coscReg) | (busy ? srcNeeds(targetReg) : '0);
    // RQ11 old source stops, exceptions kept
    wire cswref_osc_t keepOn = '{pll: 1'b0, low_power_rc_oscillator: wdtEnabled | fscmEnabled,
                                sec: soscenReg, pri: 1'b0, fast_rc_oscillator: 1'b0};
    // RQ19 primary kept in sleep only on request
    wire cswref_osc_t sleepOn = '{pll: 1'b0, low_power_rc_oscillator: wdtEnabled, sec: soscenReg,
                                 pri: poscenReg, fast_rc_oscillator: 1'b0};
    wire cswref_osc_t oscNext = sleepMode ? sleepOn : (runNeeds | keepOn);
    // RQ19 sleep gating of reference
    wire refRun = roEnable & (~sleepMode | (roSleepRun & roSelPrimary));
    // RQ18 base clock select
    wire refBase = roSelPrimary ? primaryClk : systemClk;

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            oscEnable <= '0;
            sysClkSource <= SRC_FRC;
            primarySubmode <= 2'h0;
            refclkOe <= 1'b0;
        end else begin
            // RQ8 target started
            oscEnable <= oscNext;
            sysClkSource <= coscReg;
            primarySubmode <= cfgReg.primarySubmode;
            refclkOe <= refRun;
        end
    end

    cswref_refclk_div refDivider (
        .clock(clock),
        .rstSync(rstSync),
        .enable(refRun),
        .divisor(roDivisor),
        .baseClk(refBase),
        .refOut(refclkPin)
    );

    // =========================================================================
    // apb answer: one wait state, never held for the sequencer
    wire [15:0] oscRead = {1'b0, coscReg, 1'b0, noscReg, clklockReg, 1'b0, lockReg,
                           1'b0, cfReg, poscenReg, soscenReg, oswenReg & switchEnabled};
    wire [15:0] readWord = oscHit ? oscRead : refHit ? refCtrlReg : 16'h0000;
    wire setupOk = psel & penable & ~pready;

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            // RQ12 fixed latency
            pready <= setupOk;
            prdata <= (setupOk && !pwrite) ? {16'h0000, readWord} : 32'h0000_0000;
            pslverr <= setupOk & ~(oscHit | refHit);
        end
    end

    // =========================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);

    sequence switchTail;
        stateReg == ST_SWITCH ##1 (stateReg == ST_IDLE && !oswenReg);
    endsequence

    switch_off_a: assert property (!switchEnabled |-> stateReg == ST_IDLE) // RQ1
        else $error("sequencer active while switching disabled");
    cur_from_cfg_a: assert property (cfgLoadedReg && !switchEnabled |=> // RQ2
        coscReg == $past(cfgReg.resetSource)) else $error("current source not from config");
    req_zero_a: assert property (!switchEnabled |=> !oswenReg) // RQ3
        else $error("request bit set while switching disabled");
    hi_unlock_a: assert property ($past(cfgLoadedReg) && noscReg != $past(noscReg) |-> // RQ4
        $past(hiCommit)) else $error("new source changed without unlock");
    lo_unlock_a: assert property ($rose(oswenReg) |-> $past(loCommit)) // RQ5
        else $error("request set without low byte unlock");
    redundant_a: assert property (stateReg == ST_IDLE && oswenReg && switchEnabled && // RQ6
        redundant && !swSetOswen |=> !oswenReg && stateReg == ST_IDLE)
        else $error("redundant request not aborted");
    accept_clr_a: assert property (accept && !oscStat.clockFail |=> !cfReg && !lockReg) // RQ7
        else $error("lock or fail flag kept on accept");
    wait_ready_a: assert property (stateReg == ST_WAIT && !targetReady |=> // RQ8
        stateReg == ST_WAIT) else $error("left wait before target ready");
    settle_a: assert property ($rose(stateReg == ST_SWITCH) |-> // RQ9
        $past(settleCnt) == SETTLE_COUNT - 4'h1 && $past(oscStat.newClkTick))
        else $error("switched before ten new-clock cycles");
    done_a: assert property ($rose(stateReg == ST_SWITCH) |-> switchTail) // RQ10
        else $error("switch completion sequence wrong");
    done_copy_a: assert property (stateReg == ST_SWITCH |=> coscReg == $past(targetReg)) // RQ10
        else $error("current source not updated");
    bus_ready_a: assert property (setupOk |=> pready) // RQ12
        else $error("bus answer delayed");
    locked_a: assert property (selLocked && !busy |=> !$rose(oswenReg)) // RQ22
        else $error("request accepted while selection locked");
endmodule

// ===== src/cswref_pkg.sv
// cswref_pkg: constants, register layout and carrier types for the clock
// switch controller and its reference clock output.
// assumes one 20 MHz clock; oscillator analog parts live outside the block.
package cswref_pkg;

    // =========================================================================
    // register map (byte addresses on the 12-bit APB address)
    localparam logic [11:0] OSC_CTRL_OFS = 12'h000;
    localparam logic [11:0] REF_CTRL_OFS = 12'h004;

    // =========================================================================
    // unlock keys
    localparam logic [7:0] KEY_HI_FIRST = 8'h78;
    localparam logic [7:0] KEY_HI_SECOND = 8'h9A;
    localparam logic [7:0] KEY_LO_FIRST = 8'h46;
    localparam logic [7:0] KEY_LO_SECOND = 8'h57;

    // =========================================================================
    // oscillator_control_reg fields
    localparam int COSC_LSB = 12;
    localparam int NOSC_LSB = 8;
    localparam int CLOCK_SELECT_LOCK_BIT = 7;
    localparam int LOCK_BIT = 5;
    localparam int CF_BIT = 3;
    localparam int PRIMARY_KEEP_IN_SLEEP_BIT = 2;
    localparam int SECONDARY_OSC_ENABLE_BIT = 1;
    localparam int SWITCH_REQUEST_BIT_BIT = 0;

    // =========================================================================
    // reference_clock_control fields
    localparam int REFCLK_OUTPUT_ENABLE_BIT = 15;
    localparam int RO_SLEEP_BIT = 13;
    localparam int RO_SEL_BIT = 12;
    localparam int RO_DIV_LSB = 8;
    localparam logic [15:0] REF_CTRL_RESET = 16'h0000;
    localparam logic [15:0] REF_CTRL_MASK = 16'hBF00;

    // =========================================================================
    // timing and submodes
    localparam logic [3:0] SETTLE_COUNT = 4'hA;
    localparam logic [1:0] SUBMODE_EC = 2'h0;

    typedef enum logic [2:0] {
        SRC_FRC = 3'b000,
        SRC_FRC_PLL = 3'b001,
        SRC_PRI = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_SEC = 3'b100,
        SRC_LOW_POWER_RC_OSCILLATOR = 3'b101,
        SRC_RSVD = 3'b110,
        SRC_FRC_DIV = 3'b111
    } cswref_src_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_WAIT = 3'b010,
        ST_SETTLE = 3'b011,
        ST_SWITCH = 3'b100
    } cswref_state_t;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_FIRST = 2'b01,
        KEY_OPEN = 2'b10
    } cswref_key_t;

    // oscillator enables, one bit per physical source
    typedef struct packed {
        logic pll;
        logic low_power_rc_oscillator;
        logic sec;
        logic pri;
        logic fast_rc_oscillator;
    } cswref_osc_t;

    // oscillator status, synchronous to clock
    typedef struct packed {
        logic ostExpired;
        logic pllLocked;
        logic newClkTick;
        logic clockFail;
    } cswref_osc_stat_t;

    // configuration word bits, sampled once after reset release
    typedef struct packed {
        logic switchDisable;
        logic fscmDisable;
        logic [2:0] resetSource;
        logic [1:0] primarySubmode;
    } cswref_cfg_t;

    localparam cswref_cfg_t CFG_RESET = '{1'b1, 1'b1, 3'b000, 2'b00};

endpackage

// ===== src/cswref_refclk_div.sv
// cswref_refclk_div: divides a sampled base clock by two to the divisor.
// assumes baseClk is a level sampled synchronously to clock and at most
// half its rate; rstSync is the already synchronised reset.
module cswref_refclk_div (
    // clock and reset
    input wire logic clock,
    input wire logic rstSync,
    // control
    input wire logic enable,
    input wire logic [3:0] divisor,
    input wire logic baseClk,
    // output
    output logic refOut
);
    import cswref_pkg::*;

    logic baseDlyReg;
    logic [14:0] countReg;
    logic [14:0] countNext;
    logic refNext;
    wire baseRise = baseClk & ~baseDlyReg;
    wire [3:0] tapSel = divisor - 4'h1;

    // =========================================================================
    // divider
    // RQ20 power of two
    assign countNext = !enable ? 15'h0000 : (baseRise ? countReg + 15'h0001 : countReg);
    // RQ17 output gate
    assign refNext = !enable ? 1'b0 : (divisor == 4'h0) ? baseClk : countReg[tapSel];

    always_ff @(posedge clock or negedge rstSync) begin
        if (!rstSync) begin
            baseDlyReg <= 1'b0;
            countReg <= 15'h0000;
            refOut <= 1'b0;
        end else begin
            baseDlyReg <= baseClk;
            countReg <= countNext;
            refOut <= refNext;
        end
    end

    // =========================================================================
    // checks
    ref_gate_off_a: assert property (@(posedge clock) disable iff (!rstSync) // RQ17
        !enable |=> !refOut) else $error("reference output active while disabled");
    ref_pass_a: assert property (@(posedge clock) disable iff (!rstSync) // RQ20
        enable && divisor == 4'h0 |=> refOut == $past(baseClk))
        else $error("undivided reference does not follow base clock");
    ref_div2_a: assert property (@(posedge clock) disable iff (!rstSync) // RQ20
        enable && divisor == 4'h1 && $past(enable) && baseRise ##1 enable && divisor == 4'h1
        |=> refOut != $past(refOut)) else $error("divide by two does not toggle on base edge");
endmodule

// ===== tb/tb_clock_switch_and_refclk.sv
// tb_clock_switch_and_refclk: self-checking bench for the clock switch block.
// assumes the package is compiled first; the bench drives every port itself.
module tb_clock_switch_and_refclk;
    timeunit 1ns;
    timeprecision 1ns;
    import cswref_pkg::*;
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, refclkPin, refclkOe, errSeen;
    logic wdtEnabled = 0, sleepMode = 0, primaryClk = 0, systemClk = 0;
    cswref_cfg_t cfgWord = CFG_RESET;
    cswref_osc_stat_t oscStat = '0;
    cswref_osc_t oscEnable;
    cswref_src_t sysClkSource;
    logic [1:0] primarySubmode;
    int error_cnt = 0, checks = 0, cyc = 0;

    cswref_clock_switch i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .cfgWord, .wdtEnabled, .sleepMode,
        .oscStat, .oscEnable, .sysClkSource, .primarySubmode, .primaryClk, .systemClk,
        .refclkPin, .refclkOe);

    // =========================================================================
    // clock, half-rate base clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) systemClk <= ~systemClk;
    always @(posedge clock) primaryClk <= ~primaryClk;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // =========================================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        errSeen = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask

    task automatic rdreg(input logic [11:0] a);
        apb(0, a, '0, '0);
    endtask

    // key bytes go to both lanes, the strobe picks the byte
    // unlock writes interleaved only by the stray write when stray is set
    task automatic unlock_write(input logic hi, input logic stray, input logic [7:0] v);
        logic [7:0] k1, k2;
        k1 = hi ? KEY_HI_FIRST : KEY_LO_FIRST;
        k2 = hi ? KEY_HI_SECOND : KEY_LO_SECOND;
        apb(1, OSC_CTRL_OFS, {16'h0000, k1, k1}, hi ? 4'h2 : 4'h1);
        apb(1, OSC_CTRL_OFS, {16'h0000, k2, k2}, hi ? 4'h2 : 4'h1);
        if (stray) apb(1, REF_CTRL_OFS, '0, 4'h3);
        apb(1, OSC_CTRL_OFS, {16'h0000, v, v}, hi ? 4'h2 : 4'h1);
    endtask

    task automatic do_reset(input logic dis, input cswref_src_t src);
        rst_n <= 0;
        cfgWord <= '{dis, dis, src, {dis, 1'b0}};
        repeat (5) @(posedge clock);
        rst_n <= 1;
        repeat (6) @(posedge clock);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            oscStat.newClkTick <= 1;
            @(posedge clock);
            oscStat.newClkTick <= 0;
            @(posedge clock);
        end
    endtask

    // =========================================================================
    // scenarios
    task automatic t_disabled;
        do_reset(1, SRC_PRI);
        unlock_write(1, 0, {5'b0, SRC_SEC});
        unlock_write(0, 0, 8'h01);
        repeat (20) @(posedge clock);
        rdreg(OSC_CTRL_OFS);
        chk(rdat[0], 1'b0);
        chk(rdat[14:12], SRC_PRI);
        chk(sysClkSource, SRC_PRI);
        chk(primarySubmode, 2'b10);
    endtask

    task automatic t_switch;
        do_reset(0, SRC_FRC);
        unlock_write(1, 1, {5'b0, SRC_SEC});
        rdreg(OSC_CTRL_OFS);
        chk(rdat[10:8], SRC_FRC);
        unlock_write(0, 0, 8'h01);
        repeat (4) @(posedge clock);
        rdreg(OSC_CTRL_OFS);
        chk(rdat[0], 1'b0);
        oscStat.clockFail <= 1;
        @(posedge clock);
        oscStat.clockFail <= 0;
        unlock_write(1, 0, {5'b0, SRC_SEC});
        rdreg(OSC_CTRL_OFS);
        chk({rdat[10:8], rdat[3]}, {SRC_SEC, 1'b1});
        // request with the fail flag written back as one
        unlock_write(0, 0, 8'h09);
        repeat (4) @(posedge clock);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[5], rdat[3]}, 2'b00);
        ticks(9);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[14:12], rdat[0]}, {SRC_FRC, 1'b1});
        ticks(1);
        repeat (4) @(posedge clock);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[14:12], rdat[0]}, {SRC_SEC, 1'b0});
        chk(sysClkSource, SRC_SEC);
        chk({oscEnable.low_power_rc_oscillator, oscEnable.sec, oscEnable.fast_rc_oscillator}, 3'b110);
        // pll mode entered from a non-pll source
        unlock_write(1, 0, {5'b0, SRC_PRI_PLL});
        unlock_write(0, 0, 8'h01);
        repeat (8) @(posedge clock);
        ticks(10);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[14:12], rdat[5], rdat[0]}, {SRC_SEC, 2'b01});
        oscStat.pllLocked <= 1;
        @(posedge clock);
        ticks(12);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[14:12], rdat[5], rdat[0]}, {SRC_PRI_PLL, 2'b10});
        // selection lock set, then a new source and a request are tried
        unlock_write(0, 0, 8'h80);
        unlock_write(1, 0, {5'b0, SRC_FRC});
        unlock_write(0, 0, 8'h81);
        rdreg(OSC_CTRL_OFS);
        chk({rdat[10:7], rdat[0]}, {SRC_PRI_PLL, 2'b10});
    endtask

    task automatic t_refclk;
        int n;
        logic prev;
        rdreg(REF_CTRL_OFS);
        chk(rdat, {16'h0000, REF_CTRL_RESET});
        apb(1, REF_CTRL_OFS, 32'h0000_C200, 4'h3);
        rdreg(REF_CTRL_OFS);
        chk(rdat, 32'h0000_8200);
        n = 0;
        prev = refclkPin;
        // base rises 64 times, divide by 4 gives 32 toggles
        repeat (128) begin
            @(posedge clock);
            if (refclkPin !== prev) n++;
            prev = refclkPin;
        end
        chk(n inside {[31:33]}, 1'b1);
        chk(refclkOe, 1'b1);
        // divide by two: one toggle per base rising edge
        apb(1, REF_CTRL_OFS, 32'h0000_8100, 4'h3);
        n = 0;
        prev = refclkPin;
        repeat (64) begin
            @(posedge clock);
            if (refclkPin !== prev) n++;
            prev = refclkPin;
        end
        chk(n inside {[31:33]}, 1'b1);
        sleepMode <= 1;
        repeat (3) @(posedge clock);
        chk(refclkOe, 1'b0);
        apb(1, REF_CTRL_OFS, 32'h0000_B000, 4'h3);
        repeat (3) @(posedge clock);
        chk(refclkOe, 1'b1);
        sleepMode <= 0;
        rdreg(12'h008);
        chk(errSeen, 1'b1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        t_disabled();
        t_switch();
        t_refclk();
        tally_and_finish();
    end
endmodule
